/* include/mads_pkg.sv */
// Purpose: constants and types for the sequencer step configuration bank
// Assumes: apb slave with 32-bit data; printed offsets are word indices
// Notes: byte address of a register is four times its index
//
// Overview of operation
// - bit 15 enables the step, resets off
// - gain bits 14:13: 1, 2, 4, 4
// - bits 12:5 read zero, writes ignored
// - bit 4: negative input ground or channel seven
// - codes 0..7 pick external channels zero-seven
// - codes 8..15 pick the internal sources
// - internal source selects negative input automatically
package mads_pkg;
  // ==========================================================
  // register indices (byte address = index * 4)
  localparam logic [7:0] STEP_ONE_INDEX = 8'h91;
  localparam logic [7:0] STEP_TWO_INDEX = 8'h92;
  localparam logic [7:0] SEQ_CONTROL_INDEX = 8'ha0;
  localparam logic [7:0] SEQ_STATUS_INDEX = 8'ha1;
  // ==========================================================
  // reset values and writable bits
  localparam logic [15:0] STEP_ONE_RESET = 16'h0001;
  localparam logic [15:0] STEP_TWO_RESET = 16'h0002;
  localparam logic [15:0] STEP_WRITE_MASK = 16'he01f;
  localparam logic CONTROL_RESET = 1'b0;
  // ==========================================================
  // field positions
  localparam int unsigned ENABLE_BIT = 15;
  localparam int unsigned GAIN_MSB = 14;
  localparam int unsigned GAIN_LSB = 13;
  localparam int unsigned NEG_BIT = 4;
  localparam int unsigned POS_MSB = 3;
  localparam int unsigned POS_LSB = 0;
  localparam int unsigned INTERNAL_BIT = 3;
  localparam int unsigned RUN_BIT = 0;
  // ==========================================================
  // gain codes and factors
  localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
  localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
  localparam logic [2:0] GAIN_FACTOR_X1 = 3'h1;
  localparam logic [2:0] GAIN_FACTOR_X2 = 3'h2;
  localparam logic [2:0] GAIN_FACTOR_X4 = 3'h4;
  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    MADS_IDLE = 2'b00,
    MADS_PICK = 2'b01,
    MADS_CONV = 2'b10
  } mads_state_t;
endpackage

/* hw/mads_step_decode.sv */
// Purpose: decode one step configuration word into converter settings
// Assumes: purely combinational
// Notes: internal sources force the negative input to automatic
`timescale 1ns/1ps
module mads_step_decode (
  // configuration word
  input wire logic [15:0] cfg,
  // decoded settings
  output logic enable,
  output logic [2:0] gain_factor,
  output logic [3:0] pos_select,
  output logic neg_auto,
  output logic neg_channel_seven
);
  logic [1:0] gain_code;

  assign enable = cfg[mads_pkg::ENABLE_BIT];
  assign gain_code = cfg[mads_pkg::GAIN_MSB:mads_pkg::GAIN_LSB];
  // both upper codes mean gain 4
  assign gain_factor = (gain_code == mads_pkg::GAIN_CODE_X1) ?
    mads_pkg::GAIN_FACTOR_X1 : (gain_code == mads_pkg::GAIN_CODE_X2) ?
    mads_pkg::GAIN_FACTOR_X2 : mads_pkg::GAIN_FACTOR_X4;
  assign pos_select = cfg[mads_pkg::POS_MSB:mads_pkg::POS_LSB];
  assign neg_auto = cfg[mads_pkg::INTERNAL_BIT];
  // select bit is ignored for internal sources
  assign neg_channel_seven = cfg[mads_pkg::NEG_BIT] &
    ~cfg[mads_pkg::INTERNAL_BIT];
endmodule

/* hw/mads_step_bank.sv */
// Purpose: apb register bank for sequencer steps one and two plus stepper
// Assumes: conv_done comes from the converter, synchronous to clock
// Notes: zero wait state; unmapped or misaligned access gives pslverr
`timescale 1ns/1ps
module mads_step_bank (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter side
  input wire logic conv_done,
  output logic conv_start,
  output logic conv_step,
  output logic [2:0] conv_gain_factor,
  output logic [3:0] conv_pos_select,
  output logic conv_neg_auto,
  output logic conv_neg_channel_seven
);
  // ==========================================================
  // reset release
  logic rst_meta_b;
  logic reset_sync_b;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      reset_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      reset_sync_b <= rst_meta_b;
    end
  end

  // ==========================================================
  // register file
  logic [15:0] step_cfg [2];
  logic [15:0] next_step_cfg [2];
  logic run;
  logic next_run;
  logic [31:0] next_prdata;
  logic setup;
  logic access;
  logic aligned;
  logic [7:0] index;
  logic mapped;
  mads_pkg::mads_state_t state;
  mads_pkg::mads_state_t next_state;
  logic step;
  logic next_step;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign aligned = (paddr[1:0] == 2'h0);
  assign index = paddr[9:2];
  assign mapped = aligned & ((index == mads_pkg::STEP_ONE_INDEX) |
    (index == mads_pkg::STEP_TWO_INDEX) |
    (index == mads_pkg::SEQ_CONTROL_INDEX) |
    (index == mads_pkg::SEQ_STATUS_INDEX));
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  always_comb begin
    next_step_cfg[0] = step_cfg[0];
    next_step_cfg[1] = step_cfg[1];
    next_run = run;
    next_prdata = prdata;
    if (access && pwrite && aligned) begin
      // reserved bits are masked off on write
      if (index == mads_pkg::STEP_ONE_INDEX) begin
        next_step_cfg[0] = pwdata[15:0] & mads_pkg::STEP_WRITE_MASK;
      end
      if (index == mads_pkg::STEP_TWO_INDEX) begin
        next_step_cfg[1] = pwdata[15:0] & mads_pkg::STEP_WRITE_MASK;
      end
      if (index == mads_pkg::SEQ_CONTROL_INDEX) begin
        next_run = pwdata[mads_pkg::RUN_BIT];
      end
    end
    // read data is fetched in the setup cycle
    if (setup) begin
      next_prdata = 32'h0000_0000;
      if (aligned && !pwrite) begin
        case (index)
          mads_pkg::STEP_ONE_INDEX: begin
            next_prdata = {16'h0000, step_cfg[0]};
          end
          mads_pkg::STEP_TWO_INDEX: begin
            next_prdata = {16'h0000, step_cfg[1]};
          end
          mads_pkg::SEQ_CONTROL_INDEX: begin
            next_prdata = {31'h0000_0000, run};
          end
          mads_pkg::SEQ_STATUS_INDEX: begin
            next_prdata = {29'h0000_0000, state == mads_pkg::MADS_CONV,
              step, state != mads_pkg::MADS_IDLE};
          end
          default: begin
            next_prdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge reset_sync_b) begin
    if (!reset_sync_b) begin
      step_cfg[0] <= mads_pkg::STEP_ONE_RESET;
      step_cfg[1] <= mads_pkg::STEP_TWO_RESET;
      run <= mads_pkg::CONTROL_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      step_cfg[0] <= next_step_cfg[0];
      step_cfg[1] <= next_step_cfg[1];
      run <= next_run;
      prdata <= next_prdata;
    end
  end

  // ==========================================================
  // step decode
  logic dec_enable [2];
  logic [2:0] dec_gain [2];
  logic [3:0] dec_pos [2];
  logic dec_auto [2];
  logic dec_seven [2];

  for (genvar g = 0; g < 2; g++) begin : gen_decode
    mads_step_decode u_decode (
      .cfg(step_cfg[g]),
      .enable(dec_enable[g]),
      .gain_factor(dec_gain[g]),
      .pos_select(dec_pos[g]),
      .neg_auto(dec_auto[g]),
      .neg_channel_seven(dec_seven[g])
    );
  end

  // ==========================================================
  // sequencer
  logic next_start;
  logic [2:0] next_gain;
  logic [3:0] next_pos;
  logic next_auto;
  logic next_seven;

  always_comb begin
    next_state = state;
    next_step = step;
    next_start = 1'b0;
    next_gain = conv_gain_factor;
    next_pos = conv_pos_select;
    next_auto = conv_neg_auto;
    next_seven = conv_neg_channel_seven;
    case (state)
      mads_pkg::MADS_IDLE: begin
        if (run) begin
          next_state = mads_pkg::MADS_PICK;
          next_step = 1'b0;
        end
      end
      mads_pkg::MADS_PICK: begin
        if (!run) begin
          next_state = mads_pkg::MADS_IDLE;
        end else if (dec_enable[step]) begin
          // latch this step's settings for its conversion
          next_start = 1'b1;
          next_gain = dec_gain[step];
          next_pos = dec_pos[step];
          next_auto = dec_auto[step];
          next_seven = dec_seven[step];
          next_state = mads_pkg::MADS_CONV;
        end else begin
          next_step = step + 1'b1;
        end
      end
      mads_pkg::MADS_CONV: begin
        if (conv_done) begin
          next_step = step + 1'b1;
          next_state = run ? mads_pkg::MADS_PICK : mads_pkg::MADS_IDLE;
        end
      end
      default: begin
        next_state = mads_pkg::MADS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_sync_b) begin
    if (!reset_sync_b) begin
      state <= mads_pkg::MADS_IDLE;
      step <= 1'b0;
      conv_start <= 1'b0;
      conv_gain_factor <= mads_pkg::GAIN_FACTOR_X1;
      conv_pos_select <= 4'h0;
      conv_neg_auto <= 1'b0;
      conv_neg_channel_seven <= 1'b0;
    end else begin
      state <= next_state;
      step <= next_step;
      conv_start <= next_start;
      conv_gain_factor <= next_gain;
      conv_pos_select <= next_pos;
      conv_neg_auto <= next_auto;
      conv_neg_channel_seven <= next_seven;
    end
  end

  assign conv_step = step;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_sync_b);

  step_enable_a: assert property (
    conv_start |-> $past(step_cfg[step][mads_pkg::ENABLE_BIT]))
    else $error("conversion started on a disabled step");
  gain_map_a: assert property (
    conv_start |-> conv_gain_factor ==
      (($past(step_cfg[step][14:13]) == 2'h0) ? 3'h1 :
       ($past(step_cfg[step][14:13]) == 2'h1) ? 3'h2 : 3'h4))
    else $error("gain factor does not match gain code");
  reserved_read_a: assert property (
    (access && !pwrite && aligned && (index == mads_pkg::STEP_ONE_INDEX ||
      index == mads_pkg::STEP_TWO_INDEX)) |-> prdata[12:5] == 8'h00)
    else $error("reserved bits read nonzero");
  write_mask_a: assert property (
    (access && pwrite && aligned && index == mads_pkg::STEP_ONE_INDEX)
      |=> step_cfg[0] == ($past(pwdata[15:0]) & 16'he01f))
    else $error("step one write not stored as masked");
  neg_select_a: assert property (
    (conv_start && !conv_neg_auto) |->
      conv_neg_channel_seven == $past(step_cfg[step][4]))
    else $error("negative input select not applied");
  pos_select_a: assert property (
    conv_start |-> conv_pos_select == $past(step_cfg[step][3:0]))
    else $error("positive input select not applied");
  internal_src_a: assert property (
    conv_start |-> conv_neg_auto == $past(step_cfg[step][3]))
    else $error("internal source flag wrong");
  auto_neg_a: assert property (
    conv_neg_auto |-> !conv_neg_channel_seven)
    else $error("negative select honoured for internal source");
  seq_advance_a: assert property (
    (state == mads_pkg::MADS_CONV && conv_done && run) |=>
      state == mads_pkg::MADS_PICK && step != $past(step))
    else $error("sequencer did not advance after conversion");
endmodule

/* bench/mads_testbench.sv */
// Purpose: self-checking bench for the sequencer step configuration bank
// Assumes: zero wait state apb slave, byte address is four times the index
// Notes: converter is played by the bench through conv_done
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic conv_done = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic conv_start;
  logic conv_step;
  logic [2:0] conv_gain_factor;
  logic [3:0] conv_pos_select;
  logic conv_neg_auto;
  logic conv_neg_channel_seven;
  logic [31:0] rd;
  logic err;
  logic [31:0] cfg;
  logic [2:0] gexp;
  int miscompares = 0;
  int cmp_count = 0;
  localparam logic [9:0] one_addr = {mads_pkg::STEP_ONE_INDEX, 2'b00};
  localparam logic [9:0] two_addr = {mads_pkg::STEP_TWO_INDEX, 2'b00};
  localparam logic [9:0] ctl_addr = {mads_pkg::SEQ_CONTROL_INDEX, 2'b00};

  always #2.5 clock = ~clock;

  mads_step_bank dut (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
    .conv_start(conv_start), .conv_step(conv_step),
    .conv_gain_factor(conv_gain_factor), .conv_pos_select(conv_pos_select),
    .conv_neg_auto(conv_neg_auto),
    .conv_neg_channel_seven(conv_neg_channel_seven)
  );

  // ==========================================================
  // reporting
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ==========================================================
  // apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [9:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // start the sequencer and wait for the start pulse
  task catch_start;
    int n;
    apb(1'b1, ctl_addr, 32'h1, rd, err);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (conv_start !== 1'b1 && n < 20);
    if (conv_start !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask

  // finish the running conversion with run still set, wait for next start
  task next_start;
    int n;
    @(posedge clock);
    conv_done <= 1'b1;
    @(posedge clock);
    conv_done <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (conv_start !== 1'b1 && n < 20);
    if (conv_start !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask

  // stop the sequencer and finish the running conversion
  task stop_seq;
    apb(1'b1, ctl_addr, 32'h0, rd, err);
    @(posedge clock);
    conv_done <= 1'b1;
    @(posedge clock);
    conv_done <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'b0, one_addr, 32'h0, rd, err);
    check("step one reset", rd, 32'h0000_0001);
    apb(1'b0, two_addr, 32'h0, rd, err);
    check("step two reset", rd, 32'h0000_0002);
    apb(1'b1, one_addr, 32'hffff_ffff, rd, err);
    apb(1'b0, one_addr, 32'h0, rd, err);
    check("reserved bits", rd, 32'h0000_e01f);
    apb(1'b0, 10'h3fc, 32'h0, rd, err);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped read", rd, 32'h0);
    apb(1'b0, one_addr + 10'h1, 32'h0, rd, err);
    check("misaligned error", {31'h0, err}, 32'h1);
    check("misaligned read", rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      cfg = {16'h0, 1'b1, i[1:0], 8'h00, i[2], i[3:0]};
      gexp = (i[1:0] == 2'h0) ? 3'h1 : (i[1:0] == 2'h1) ? 3'h2 : 3'h4;
      apb(1'b1, one_addr, cfg, rd, err);
      apb(1'b0, one_addr, 32'h0, rd, err);
      check("step one word", rd, cfg);
      catch_start();
      check("step", {31'h0, conv_step}, 32'h0);
      check("gain", {29'h0, conv_gain_factor}, {29'h0, gexp});
      check("pos", {28'h0, conv_pos_select}, i[3:0]);
      check("neg auto", {31'h0, conv_neg_auto}, i[3]);
      check("neg seven", {31'h0, conv_neg_channel_seven},
            i[3] ? 32'h0 : i[2]);
      stop_seq();
    end
    apb(1'b1, one_addr, 32'h0000_0003, rd, err);
    apb(1'b1, two_addr, 32'h0000_8002, rd, err);
    catch_start();
    check("skip disabled", {31'h0, conv_step}, 32'h1);
    check("step two pos", {28'h0, conv_pos_select}, 32'h2);
    apb(1'b0, ctl_addr, 32'h0, rd, err);
    check("run bit", rd, 32'h1);
    apb(1'b0, ctl_addr + 10'h4, 32'h0, rd, err);
    check("status converting", rd, 32'h7);
    // step two done while running: wraps to disabled step one, skips it
    next_start();
    check("wrap skip", {31'h0, conv_step}, 32'h1);
    check("wrap gain", {29'h0, conv_gain_factor}, 32'h1);
    check("wrap pos", {28'h0, conv_pos_select}, 32'h2);
    stop_seq();
    // reset in mid-conversion brings back the reset values
    catch_start();
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    check("start after reset", {31'h0, conv_start}, 32'h0);
    apb(1'b0, one_addr, 32'h0, rd, err);
    check("step one after reset", rd, 32'h0000_0001);
    apb(1'b0, two_addr, 32'h0, rd, err);
    check("step two after reset", rd, 32'h0000_0002);
    apb(1'b0, ctl_addr, 32'h0, rd, err);
    check("run after reset", rd, 32'h0);
    finish_test();
  end
endmodule
